/* File: rtl/sdram_cmd_params.svh */
// constants for the sdram command decode and burst engine
// assumes inclusion by the core module only
`ifndef SDRAM_CMD_PARAMS_SVH
`define SDRAM_CMD_PARAMS_SVH
`define MR_BL_LSB      0
`define MR_BL_MSB      2
`define MR_BT_BIT      3
`define MR_CL_LSB      4
`define MR_CL_MSB      6
`define MR_OM_LSB      7
`define MR_OM_MSB      8
`define MR_WB_BIT      9
`define BL_CODE_1      3'h0
`define BL_CODE_2      3'h1
`define BL_CODE_4      3'h2
`define BL_CODE_8      3'h3
`define BL_CODE_FULL   3'h7
`define CL_CODE_2      3'h2
`define CL_CODE_3      3'h3
`define OM_NORMAL      2'h0
`define MR_RESET       12'h0_000
`endif

/* File: rtl/sdram_cmd_pkg.sv */
// types for the sdram command decode and burst engine
// assumes the params header is included alongside
package sdram_cmd_pkg;
	typedef enum logic [3:0] {
		CMD_NOP   = 4'h0,
		CMD_ACT   = 4'h1,
		CMD_RD    = 4'h2,
		CMD_WR    = 4'h3,
		CMD_BST   = 4'h4,
		CMD_PRE   = 4'h5,
		CMD_REF   = 4'h6,
		CMD_SREF  = 4'h7,
		CMD_LMR   = 4'h8,
		CMD_INH   = 4'h9
	} cmd_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_READ  = 3'b010,
		ST_WRITE = 3'b100
	} burst_st_t;
endpackage

/* File: rtl/sdram_cmd_core.sv */
// command decode, mode register and burst column sequencer of an sdram
// assumes pins are already synchronous to sys_clk from the controller
`timescale 1ns/1ps
`include "sdram_cmd_params.svh"

// Summary of operation
// R1 - sequential bursts increment, interleaved XOR beat index, wrapping in block
// R2 - lengths 2/4/8 use low column bits as start, upper bits fix block
// R3 - full page covers whole row, sequential only, interleaved unsupported
// R4 - burst length one accesses the given column only, type ignored
// R5 - read latency accepts two or three clocks only
// R6 - read at edge n drives data from n+m-1, valid by n+m
// R7 - only zero operating mode bits select normal operation
// R8 - write burst mode bit set makes every write single location
// R9 - chip select and strobes decode into the ten commands
// R10 - chip select high takes no command, bursts continue
// R11 - no-op takes nothing new, bursts continue
// R12 - activate takes row from address and bank from bank bits
// R13 - read or write take column, bank, and A10 as auto precharge; full page bursts ignore A10
// R14 - precharge closes named bank, or all banks with A10 high
// R15 - refresh encoding is auto refresh with cke high, self refresh low
// R16 - refresh row comes from an internal counter
// R17 - load mode writes address inputs into the mode register
// R18 - byte mask zero delay on writes, two clocks on reads
// R19 - controller loads mode only with banks idle, then waits
// R20 - mode fields: length 0-2, type 3, latency 4-6, mode 7-8, wb 9
// R21 - lengths 1,2,4,8 both types; full page sequential only
// R22 - data outputs high impedance except while read data presented
module sdram_cmd_core
	import sdram_cmd_pkg::*;
#(
	parameter int COL_W = 10,
	parameter int DQ_W  = 4
)(
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	// command pins
	input  wire logic                  cke,
	input  wire logic                  cs_b,
	input  wire logic                  ras_b,
	input  wire logic                  cas_b,
	input  wire logic                  we_b,
	input  wire logic [1:0]            ba,
	input  wire logic [11:0]           addr,
	input  wire logic                  dqm,
	// data pins
	input  wire logic [DQ_W-1:0]       dq_in,
	output logic      [DQ_W-1:0]       dq_out,
	output logic                       dq_oe_b,
	// array side
	output logic      [1:0]            arr_bank,
	output logic      [11:0]           arr_row,
	output logic      [COL_W-1:0]      arr_col,
	output logic                       arr_rd,
	output logic                       arr_wr,
	output logic      [DQ_W-1:0]       arr_wdata,
	input  wire logic [DQ_W-1:0]       arr_rdata,
	output logic      [3:0]            bank_open,
	output logic                       auto_pre,
	output logic                       refresh_q,
	output logic                       self_ref_q,
	output logic                       mode_ok
);
	localparam int CNT_W = COL_W + 1;

	logic [11:0]       mode_q;
	cmd_t              cmd;
	burst_st_t         st_q;
	logic [COL_W-1:0]  start_q;
	logic [CNT_W-1:0]  beat_q;
	logic [CNT_W-1:0]  len_q;
	logic              il_q;
	logic [11:0]       ref_row_q;
	logic [11:0]       row_q [4];
	logic              rd_dly_q;
	logic [DQ_W-1:0]   rd_data_q;
	logic              dqm_q;
	logic              ap_pend_q;
	logic [CNT_W-1:0]  len_d;
	logic [COL_W-1:0]  col_d;
	logic [COL_W-1:0]  off_d;
	logic [COL_W-1:0]  mask_d;
	logic              last_d;

	// pin decode, inhibit wins over everything
	always_comb
	begin
		if (cs_b)
			cmd = CMD_INH; // R10
		else
			case ({ras_b, cas_b, we_b}) // R9
				3'b111:  cmd = CMD_NOP; // R11
				3'b011:  cmd = CMD_ACT;
				3'b101:  cmd = CMD_RD;
				3'b100:  cmd = CMD_WR;
				3'b110:  cmd = CMD_BST;
				3'b010:  cmd = CMD_PRE;
				3'b001:  cmd = cke ? CMD_REF : CMD_SREF; // R15
				3'b000:  cmd = CMD_LMR;
				default: cmd = CMD_NOP;
			endcase
	end

	// burst span from mode and direction
	always_comb
	begin
		len_d = CNT_W'(1);
		case (mode_q[`MR_BL_MSB:`MR_BL_LSB]) // R21
			`BL_CODE_1:    len_d = CNT_W'(1); // R4
			`BL_CODE_2:    len_d = CNT_W'(2);
			`BL_CODE_4:    len_d = CNT_W'(4);
			`BL_CODE_8:    len_d = CNT_W'(8);
			`BL_CODE_FULL: len_d = CNT_W'(1) << COL_W; // R3
			default:       len_d = CNT_W'(1);
		endcase
		if (cmd == CMD_WR && mode_q[`MR_WB_BIT])
			len_d = CNT_W'(1); // R8
	end

	// column of the current beat, wrapped in the aligned block
	always_comb
	begin
		mask_d = len_q[COL_W] ? '1 : COL_W'(len_q - CNT_W'(1)); // R2
		if (il_q)
			off_d = start_q ^ beat_q[COL_W-1:0]; // R1
		else
			off_d = start_q + beat_q[COL_W-1:0]; // R1
		col_d  = (start_q & ~mask_d) | (off_d & mask_d); // R2
		last_d = (beat_q + CNT_W'(1)) == len_q;
	end

	always_ff @(posedge sys_clk)
		if (!rst_b)
			mode_q <= `MR_RESET;
		else if (cmd == CMD_LMR)
			mode_q <= addr; // R17

	// full page never interleaves; one beat ignores type anyway
	always_ff @(posedge sys_clk)
		if (!rst_b)
		begin
			st_q    <= ST_IDLE;
			start_q <= '0;
			beat_q  <= '0;
			len_q   <= CNT_W'(1);
			il_q    <= 1'b0;
		end
		else if (cmd == CMD_RD || cmd == CMD_WR)
		begin
			// beat zero issues on the command edge itself
			if (len_d == CNT_W'(1))
				st_q <= ST_IDLE; // R4
			else
				st_q <= (cmd == CMD_RD) ? ST_READ : ST_WRITE;
			start_q <= addr[COL_W-1:0]; // R13
			beat_q  <= CNT_W'(1);
			len_q   <= len_d;
			il_q    <= mode_q[`MR_BT_BIT] && !len_d[COL_W]; // R3
		end
		else
			case (st_q)
				ST_READ, ST_WRITE:
					if (cmd == CMD_BST || last_d)
					begin
						st_q   <= ST_IDLE;
						beat_q <= '0;
					end
					else
						beat_q <= beat_q + CNT_W'(1);
				ST_IDLE: beat_q <= '0;
				default: st_q <= ST_IDLE;
			endcase

	always_ff @(posedge sys_clk)
		if (!rst_b)
			auto_pre <= 1'b0;
		else if (cmd == CMD_RD || cmd == CMD_WR)
			auto_pre <= addr[10] && !len_d[COL_W]; // R13

	// pending close of the burst's bank once the burst is over
	always_ff @(posedge sys_clk)
		if (!rst_b)
			ap_pend_q <= 1'b0;
		else if (cmd == CMD_RD || cmd == CMD_WR)
			ap_pend_q <= addr[10] && !len_d[COL_W]; // R13
		else if (st_q == ST_IDLE)
			ap_pend_q <= 1'b0;

	// bank bookkeeping
	always_ff @(posedge sys_clk)
		if (!rst_b)
			bank_open <= 4'h0;
		else if (cmd == CMD_ACT)
			bank_open[ba] <= 1'b1; // R12
		else if (cmd == CMD_PRE)
		begin
			if (addr[10])
				bank_open <= 4'h0; // R14
			else
				bank_open[ba] <= 1'b0; // R14
		end
		else if (ap_pend_q && st_q == ST_IDLE)
			bank_open[arr_bank] <= 1'b0; // R13

	always_ff @(posedge sys_clk)
		if (!rst_b)
		begin
			for (int i = 0; i < 4; i++)
				row_q[i] <= 12'h0_000;
			arr_bank <= 2'h0;
		end
		else if (cmd == CMD_ACT)
		begin
			row_q[ba] <= addr; // R12
			arr_bank  <= ba;
		end
		else if (cmd == CMD_RD || cmd == CMD_WR)
			arr_bank <= ba; // R13

	// refresh row counter
	always_ff @(posedge sys_clk)
		if (!rst_b)
		begin
			ref_row_q  <= 12'h0_000;
			refresh_q  <= 1'b0;
			self_ref_q <= 1'b0;
		end
		else
		begin
			refresh_q <= (cmd == CMD_REF); // R15
			if (cmd == CMD_REF)
				ref_row_q <= ref_row_q + 12'h0_001; // R16
			if (cmd == CMD_SREF)
				self_ref_q <= 1'b1; // R15
			else if (cke)
				self_ref_q <= 1'b0;
		end

	// array strobes; write mask acts on the same beat
	always_ff @(posedge sys_clk)
		if (!rst_b)
		begin
			arr_row   <= 12'h0_000;
			arr_col   <= '0;
			arr_rd    <= 1'b0;
			arr_wr    <= 1'b0;
			arr_wdata <= '0;
			mode_ok   <= 1'b0;
		end
		else
		begin
			if (cmd == CMD_RD || cmd == CMD_WR)
			begin
				arr_row <= refresh_q ? ref_row_q : row_q[ba]; // R16
				arr_col <= addr[COL_W-1:0]; // R13
				arr_rd  <= (cmd == CMD_RD);
				arr_wr  <= (cmd == CMD_WR) && !dqm; // R18
			end
			else
			begin
				// terminate stops the beat on its own edge
				arr_row <= refresh_q ? ref_row_q : row_q[arr_bank]; // R16
				arr_col <= col_d;
				arr_rd  <= (st_q == ST_READ) && (cmd != CMD_BST);
				arr_wr  <= (st_q == ST_WRITE) && (cmd != CMD_BST)
					&& !dqm; // R18
			end
			arr_wdata <= dq_in;
			mode_ok   <= (mode_q[`MR_OM_MSB:`MR_OM_LSB] == `OM_NORMAL)
				&& (mode_q[`MR_CL_MSB:`MR_CL_LSB] == `CL_CODE_2
				|| mode_q[`MR_CL_MSB:`MR_CL_LSB] == `CL_CODE_3); // R5 R7
		end

	// read pipe: beat taken at edge n is driven on the pins from n+m-1
	always_ff @(posedge sys_clk)
		if (!rst_b)
		begin
			rd_dly_q  <= 1'b0;
			dqm_q     <= 1'b1;
			rd_data_q <= '0;
		end
		else
		begin
			rd_dly_q  <= arr_rd;
			dqm_q     <= dqm; // R18
			rd_data_q <= arr_rdata;
		end

	// latency tap; an unsupported code reads as no output at all
	logic cl3;
	logic rd_tap;
	assign cl3    = mode_q[`MR_CL_MSB:`MR_CL_LSB] == `CL_CODE_3;
	assign rd_tap = cl3 ? rd_dly_q : arr_rd;

	always_ff @(posedge sys_clk)
		if (!rst_b)
		begin
			dq_oe_b <= 1'b1;
			dq_out  <= '0;
		end
		else
		begin
			dq_oe_b <= !(rd_tap && mode_ok && !dqm_q); // R6 R18 R22
			dq_out  <= cl3 ? rd_data_q : arr_rdata;
		end

	// checks
	sequence s_lmr;
		cmd == CMD_LMR;
	endsequence

	a_mode_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_lmr |=> mode_q == $past(addr)) // R17
		else $error("mode register not loaded");
	a_prech_all: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cmd == CMD_PRE && addr[10] |=> bank_open == 4'h0) // R14
		else $error("precharge all left a bank open");
	a_act_open: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cmd == CMD_ACT |=> bank_open[$past(ba)]) // R12
		else $error("activate did not open bank");
	a_inhibit_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cs_b && st_q == ST_IDLE |=> st_q == ST_IDLE) // R10
		else $error("inhibit started a burst");
	a_wr_single: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cmd == CMD_WR && mode_q[`MR_WB_BIT] |=> len_q == CNT_W'(1)) // R8
		else $error("write burst not single");
	a_full_seq: assert property (@(posedge sys_clk) disable iff (!rst_b)
		len_q[COL_W] |-> !il_q) // R3
		else $error("full page interleaved");
	a_ref_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cmd == CMD_REF |=> ref_row_q == $past(ref_row_q) + 12'h0_001) // R16
		else $error("refresh counter stuck");
	a_dq_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!arr_rd && !rd_dly_q |=> dq_oe_b) // R22
		else $error("data driven outside read");
	a_col_block: assert property (@(posedge sys_clk) disable iff (!rst_b)
		st_q != ST_IDLE |-> (col_d & ~mask_d) == (start_q & ~mask_d)) // R2
		else $error("column left its block");
endmodule // sdram_cmd_core

/* File: test/sdram_ctrl_model.sv */
// controller model driving the sdram command pins
// assumes the bench calls its tasks; pins move on falling edges
`timescale 1ns/1ps
module sdram_ctrl_model
(
	// clock
	input  wire logic   sys_clk,
	// command pins
	output logic        cke,
	output logic        cs_b,
	output logic        ras_b,
	output logic        cas_b,
	output logic        we_b,
	output logic [1:0]  ba,
	output logic [11:0] addr,
	output logic        dqm,
	output logic [3:0]  dq_in
);
	initial
	begin
		cke = 1'b1;
		{cs_b, ras_b, cas_b, we_b} = 4'hf;
		ba = 2'h0;
		addr = 12'h0_000;
		dqm = 1'b0;
		dq_in = 4'h0;
	end
	// one command cycle, then a no-op; stale lines are inverted
	task automatic cmd(input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic [3:0] d);
		@(negedge sys_clk);
		{cs_b, ras_b, cas_b, we_b} <= c;
		ba <= b;
		addr <= a;
		dq_in <= d;
		@(negedge sys_clk);
		{cs_b, ras_b, cas_b, we_b} <= 4'h7;
		ba <= ~b;
		addr <= ~a;
		dq_in <= ~d;
	endtask
	task automatic load_mode(input logic [11:0] op);
		cmd(4'h2, 2'h0, 12'h4_00, 4'h0);
		cmd(4'h0, 2'h0, op, 4'h0);
		repeat (2) @(negedge sys_clk);
	endtask
endmodule // sdram_ctrl_model

/* File: test/testbench.sv */
// self-checking bench for the sdram command core
// assumes the controller model and a column-derived array pattern
`timescale 1ns/1ps
module testbench;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cke, cs_b, ras_b, cas_b, we_b, dqm;
	logic [1:0]  ba, arr_bank;
	logic [11:0] addr, arr_row;
	logic [3:0]  dq_in, dq_out, arr_wdata, arr_rdata, bank_open;
	logic [9:0]  arr_col;
	logic        dq_oe_b, arr_rd, arr_wr, auto_pre;
	logic        refresh_q, self_ref_q, mode_ok;
	int          err_count, compares, cyc, rd_cyc, first_dq, nref;
	logic [9:0]  cols[$];
	logic [3:0]  dqs[$];
	logic [3:0]  wd[$];

	always #4 sys_clk = ~sys_clk;
	assign arr_rdata = arr_col[3:0] ^ 4'ha;

	sdram_ctrl_model ctl (.sys_clk(sys_clk), .cke(cke), .cs_b(cs_b),
		.ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba),
		.addr(addr), .dqm(dqm), .dq_in(dq_in));
	sdram_cmd_core #(.COL_W(10), .DQ_W(4)) uut (.sys_clk(sys_clk),
		.rst_b(rst_b), .cke(cke), .cs_b(cs_b), .ras_b(ras_b),
		.cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr), .dqm(dqm),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe_b(dq_oe_b),
		.arr_bank(arr_bank), .arr_row(arr_row), .arr_col(arr_col),
		.arr_rd(arr_rd), .arr_wr(arr_wr), .arr_wdata(arr_wdata),
		.arr_rdata(arr_rdata), .bank_open(bank_open),
		.auto_pre(auto_pre), .refresh_q(refresh_q),
		.self_ref_q(self_ref_q), .mode_ok(mode_ok));

	always @(posedge sys_clk)
	begin
		cyc++;
		if (arr_rd === 1'b1 || arr_wr === 1'b1)
			cols.push_back(arr_col);
		if (arr_wr === 1'b1)
			wd.push_back(arr_wdata);
		if (dq_oe_b === 1'b0)
			dqs.push_back(dq_out);
		if (dq_oe_b === 1'b0 && first_dq < 0)
			first_dq = cyc;
		if ({cs_b, ras_b, cas_b, we_b} == 4'h5)
			rd_cyc = cyc;
		if (refresh_q === 1'b1)
			nref++;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [11:0] op(logic wb, logic [2:0] cl,
		logic bt, logic [2:0] bl);
		return {2'h0, wb, 2'h0, cl, bt, bl};
	endfunction

	task automatic rd_burst(input logic bt, input logic [2:0] blc,
		input logic [9:0] s, input int cl);
		int n;
		logic [9:0] m, e;
		n = (blc == 3'h7) ? 2 : (1 << blc);
		m = (blc == 3'h7) ? 10'h3ff : 10'(n - 1);
		ctl.load_mode(op(1'b0, 3'(cl), bt, blc));
		ctl.cmd(4'h3, 2'h1, 12'h0_0a5, 4'h0);
		cols.delete();
		dqs.delete();
		first_dq = -1;
		ctl.cmd(4'h5, 2'h1, {2'h0, s}, 4'h0);
		if (blc == 3'h7)
			ctl.cmd(4'h6, 2'h0, 12'h0_000, 4'h0);
		repeat (14) @(negedge sys_clk);
		if (blc == 3'h7)
			chk(16'(cols.size()), 16'h0_002);
		else
			chk(16'(cols.size()), 16'(n));
		chk(16'(first_dq - rd_cyc), 16'(cl));
		for (int k = 0; k < n; k++)
		begin
			e = (s & ~m) | ((bt ? (s ^ 10'(k)) : (s + 10'(k))) & m);
			chk(16'(cols[k]), 16'(e));
			chk(16'(dqs[k]), 16'(e[3:0] ^ 4'ha));
		end
	endtask

	task automatic bad_mode(input logic [11:0] o);
		ctl.load_mode(o);
		chk(16'(mode_ok), 16'h0_000);
		dqs.delete();
		ctl.cmd(4'h3, 2'h0, 12'h0_001, 4'h0);
		ctl.cmd(4'h5, 2'h0, 12'h0_000, 4'h0);
		repeat (10) @(negedge sys_clk);
		chk(16'(dqs.size()), 16'h0_000);
	endtask

	task automatic wr_burst(input logic wb);
		ctl.load_mode(op(wb, 3'h2, 1'b0, 3'h2));
		ctl.cmd(4'h3, 2'h2, 12'h0_003, 4'h0);
		cols.delete();
		wd.delete();
		ctl.cmd(4'h4, 2'h2, 12'h0_005, 4'h6);
		repeat (8) @(negedge sys_clk);
		chk(16'(cols.size()), wb ? 16'h0_001 : 16'h0_004);
		chk(16'(cols[0]), 16'h0_005);
		chk(16'(wd[0]), 16'h0_006);
	endtask

	task automatic banks;
		ctl.load_mode(op(1'b0, 3'h2, 1'b0, 3'h2));
		chk(16'(mode_ok), 16'h0_001);
		ctl.cmd(4'hb, 2'h1, 12'h0_000, 4'h0);
		ctl.cmd(4'h3, 2'h0, 12'h0_011, 4'h0);
		ctl.cmd(4'h3, 2'h3, 12'h0_022, 4'h0);
		chk(16'(bank_open), 16'h0_009);
		ctl.cmd(4'h2, 2'h3, 12'h0_000, 4'h0);
		chk(16'(bank_open), 16'h0_001);
		ctl.cmd(4'h5, 2'h0, 12'h4_00, 4'h0);
		repeat (8) @(negedge sys_clk);
		chk(16'(auto_pre), 16'h0_001);
		chk(16'(bank_open), 16'h0_000);
		chk(16'(arr_row), 16'h0_011);
		nref = 0;
		ctl.cmd(4'h1, 2'h0, 12'h0_000, 4'h0);
		repeat (2) @(negedge sys_clk);
		chk(16'(nref), 16'h0_001);
		ctl.cke <= 1'b0;
		ctl.cmd(4'h1, 2'h0, 12'h0_000, 4'h0);
		chk(16'(self_ref_q), 16'h0_001);
		ctl.cke <= 1'b1;
		repeat (2) @(negedge sys_clk);
	endtask

	task automatic complete_run;
		$display("errors=%0d compares=%0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(negedge sys_clk);
		rst_b = 1'b1;
		banks();
		for (int i = 0; i < 8; i++)
			rd_burst(i[0], 3'(i >> 1), 10'h1_3d, 2 + i[1]);
		rd_burst(1'b0, 3'h7, 10'h3_fe, 3);
		wr_burst(1'b0);
		wr_burst(1'b1);
		bad_mode(op(1'b0, 3'h1, 1'b0, 3'h2));
		bad_mode(op(1'b0, 3'h2, 1'b0, 3'h2) | 12'h0_80);
		complete_run();
	end

	initial
	begin
		repeat (4000) @(posedge sys_clk);
		err_count++;
		complete_run();
	end
endmodule // testbench
